// ==== ocic_top.sv ====
// Output contact and status input conditioner with APB register access.
// Assumes trip requests and cycle tick come from logic on pclk; status
// input pins and the target reset pushbutton are asynchronous.
//
// Overview of operation
// R1 - Latched output stays energized after tripping, condition gone or not.
// R2 - Latched output drops only on the front-panel target reset button.
// R3 - Selecting latched makes pulsed unavailable for that output.
// R4 - Picked-up contact stays energized at least its seal-in time.
// R5 - Each output has its own seal-in setting and own timer.
// R6 - Per-input polarity: open polarity asserts on contact opening.
// R7 - Neither latched nor pulsed means normal mode.
// R8 - Normal mode stays energized while the condition persists.
// R9 - Normal mode drops only after seal-in time has elapsed.
// R10 - VT phase, neutral, auxiliary ratios accept 1.0 to 6550.0.
// R11 - CT phase and neutral ratios accept 1 to 65500.
// R12 - Pulsed output drops when seal-in expires, condition or not.
// R13 - Seal-in in cycles: outputs 1-8 2..8160, others 0..65535.
// R14 - Timer starts at pickup and is not restarted while running.
`timescale 1ns/1ps
module ocic_top (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [ocic_pkg::NUM_OUT-1:0]  trip_req,
    input  wire logic                          cycle_tick,
    input  wire logic                          target_reset_pin,
    input  wire logic [ocic_pkg::NUM_IN-1:0]   status_pin,
    output logic      [ocic_pkg::NUM_OUT-1:0]  output_contact,
    output logic      [ocic_pkg::NUM_IN-1:0]   status_active,
    output logic                               irq
);

    localparam int NO = ocic_pkg::NUM_OUT;
    localparam int NI = ocic_pkg::NUM_IN;

    logic [NO-1:0] latch_ff;
    logic [NO-1:0] pulse_ff;
    logic [NI-1:0] polarity_ff;
    logic [NO-1:0] int_stat_ff;
    logic [NO-1:0] int_mask_ff;
    logic [15:0]   vt_phase_ff;
    logic [15:0]   vt_neut_ff;
    logic [15:0]   vt_aux_ff;
    logic [15:0]   ct_phase_ff;
    logic [15:0]   ct_neut_ff;
    logic [15:0]   seal_ff [NO];
    logic [NI-1:0] in_meta_ff;
    logic [NI-1:0] in_sync_ff;
    logic          clr_meta_ff;
    logic          clr_sync_ff;
    logic [NI-1:0] active_ff;
    logic          pready_ff;
    logic          pslverr_ff;
    logic [31:0]   prdata_ff;
    logic          irq_ff;
    logic [NO-1:0] contact_w;
    logic [NO-1:0] pickup_w;

    // Bus decode
    wire        acc      = psel & penable;
    wire        done     = acc & pready_ff;
    wire        wr       = done & pwrite;
    wire        sel_seal = paddr[7];
    wire [4:0]  seal_idx = paddr[6:2];
    wire        seal_ok  = sel_seal & (seal_idx < 5'(NO)) &
                           (paddr[1:0] == 2'b00);
    wire        hit_lat  = (paddr == ocic_pkg::ADDR_LATCH);
    wire        hit_pul  = (paddr == ocic_pkg::ADDR_PULSE);
    wire        hit_pol  = (paddr == ocic_pkg::ADDR_POLARITY);
    wire        hit_ins  = (paddr == ocic_pkg::ADDR_IN_STATE);
    wire        hit_outs = (paddr == ocic_pkg::ADDR_OUT_ST);
    wire        hit_ist  = (paddr == ocic_pkg::ADDR_INT_STAT);
    wire        hit_imk  = (paddr == ocic_pkg::ADDR_INT_MASK);
    wire        hit_vtp  = (paddr == ocic_pkg::ADDR_VT_PHASE);
    wire        hit_vtn  = (paddr == ocic_pkg::ADDR_VT_NEUT);
    wire        hit_vta  = (paddr == ocic_pkg::ADDR_VT_AUX);
    wire        hit_ctp  = (paddr == ocic_pkg::ADDR_CT_PHASE);
    wire        hit_ctn  = (paddr == ocic_pkg::ADDR_CT_NEUT);
    wire        hit_any  = hit_lat | hit_pul | hit_pol | hit_ins |
                           hit_outs | hit_ist | hit_imk | hit_vtp |
                           hit_vtn | hit_vta | hit_ctp | hit_ctn | seal_ok;

    wire [15:0] wdata16 = pwdata[15:0];
    wire [NO-1:0] wdata_no = pwdata[NO-1:0];

    // R3 latched masks pulsed
    wire [NO-1:0] nxt_latch = wr & hit_lat ? wdata_no : latch_ff;
    wire [NO-1:0] nxt_pulse = (wr & hit_pul ? wdata_no : pulse_ff) &
                              ~nxt_latch;

    // R10 VT ratio range
    wire [15:0] vt_clamped = ocic_pkg::ocic_clamp(wdata16,
                                 ocic_pkg::VT_RATIO_MIN,
                                 ocic_pkg::VT_RATIO_MAX);
    // R11 CT ratio range
    wire [15:0] ct_clamped = ocic_pkg::ocic_clamp(wdata16,
                                 ocic_pkg::CT_RATIO_MIN,
                                 ocic_pkg::CT_RATIO_MAX);

    // Interrupt: set wins over write-one clear
    wire [NO-1:0] ist_clr      = (wr & hit_ist) ? wdata_no : '0;
    wire [NO-1:0] nxt_int_stat = (int_stat_ff & ~ist_clr) | pickup_w;

    // Read mux
    wire [31:0] seal_rd = {16'h0000, seal_ff[seal_ok ? seal_idx : 5'h00]};
    wire [31:0] rd_mux =
        hit_lat  ? 32'(latch_ff)    :
        hit_pul  ? 32'(pulse_ff)    :
        hit_pol  ? 32'(polarity_ff) :
        hit_ins  ? 32'(active_ff)   :
        hit_outs ? 32'(contact_w)   :
        hit_ist  ? 32'(int_stat_ff) :
        hit_imk  ? 32'(int_mask_ff) :
        hit_vtp  ? 32'(vt_phase_ff) :
        hit_vtn  ? 32'(vt_neut_ff)  :
        hit_vta  ? 32'(vt_aux_ff)   :
        hit_ctp  ? 32'(ct_phase_ff) :
        hit_ctn  ? 32'(ct_neut_ff)  :
        seal_ok  ? seal_rd          : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= acc & ~pready_ff;
            pslverr_ff <= acc & ~pready_ff & ~hit_any;
            prdata_ff  <= (acc & ~pready_ff & ~pwrite) ? rd_mux : prdata_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_ff    <= '0;
            pulse_ff    <= '0;
            polarity_ff <= '0;
            int_stat_ff <= '0;
            int_mask_ff <= '0;
            irq_ff      <= 1'b0;
        end else begin
            latch_ff    <= nxt_latch;
            pulse_ff    <= nxt_pulse;
            polarity_ff <= (wr & hit_pol) ? pwdata[NI-1:0] : polarity_ff;
            int_stat_ff <= nxt_int_stat;
            int_mask_ff <= (wr & hit_imk) ? wdata_no : int_mask_ff;
            irq_ff      <= |(nxt_int_stat & int_mask_ff);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vt_phase_ff <= ocic_pkg::RST_VT_PHASE;
            vt_neut_ff  <= ocic_pkg::RST_VT_NEUT;
            vt_aux_ff   <= ocic_pkg::RST_VT_AUX;
            ct_phase_ff <= ocic_pkg::RST_CT_RATIO;
            ct_neut_ff  <= ocic_pkg::RST_CT_RATIO;
        end else begin
            vt_phase_ff <= (wr & hit_vtp) ? vt_clamped : vt_phase_ff;
            vt_neut_ff  <= (wr & hit_vtn) ? vt_clamped : vt_neut_ff;
            vt_aux_ff   <= (wr & hit_vta) ? vt_clamped : vt_aux_ff;
            ct_phase_ff <= (wr & hit_ctp) ? ct_clamped : ct_phase_ff;
            ct_neut_ff  <= (wr & hit_ctn) ? ct_clamped : ct_neut_ff;
        end
    end

    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_meta_ff  <= '0;
            in_sync_ff  <= '0;
            clr_meta_ff <= 1'b0;
            clr_sync_ff <= 1'b0;
            active_ff   <= '0;
        end else begin
            in_meta_ff  <= status_pin;
            in_sync_ff  <= in_meta_ff;
            clr_meta_ff <= target_reset_pin;
            clr_sync_ff <= clr_meta_ff;
            // R6 polarity: 1 asserts on open
            active_ff   <= in_sync_ff ^ polarity_ff;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NO; g++) begin : g_out
            localparam logic [15:0] LO = (g < ocic_pkg::NUM_SHORT) ?
                ocic_pkg::SEAL_SHORT_MIN : ocic_pkg::SEAL_LONG_MIN;
            localparam logic [15:0] HI = (g < ocic_pkg::NUM_SHORT) ?
                ocic_pkg::SEAL_SHORT_MAX : ocic_pkg::SEAL_LONG_MAX;
            localparam logic [15:0] RV = (g < ocic_pkg::NUM_SHORT) ?
                ocic_pkg::RST_SEAL_SHORT : ocic_pkg::RST_SEAL_LONG;

            wire seal_wr = wr & seal_ok & (seal_idx == 5'(g));
            ocic_pkg::ocic_chan_cfg_t cfg;

            // R13 seal-in range per output
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    seal_ff[g] <= RV;
                end else if (seal_wr) begin
                    seal_ff[g] <= ocic_pkg::ocic_clamp(wdata16, LO, HI);
                end
            end

            // R5 R7 independent channel, normal default
            assign cfg.latched = latch_ff[g];
            assign cfg.pulsed  = pulse_ff[g];
            assign cfg.seal    = seal_ff[g];

            ocic_channel u_chan (
                .pclk         (pclk),
                .presetn      (presetn),
                .cfg          (cfg),
                .trip_req     (trip_req[g]),
                .cycle_tick   (cycle_tick),
                .target_clear (clr_sync_ff),
                .contact      (contact_w[g]),
                .pickup       (pickup_w[g])
            );
        end
    endgenerate

    assign output_contact = contact_w;
    assign status_active  = active_ff;
    assign irq            = irq_ff;
    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;

endmodule // ocic_top

// ==== ocic_pkg.sv ====
// Shared constants and types of the output contact and input conditioner.
// Assumes a 10 MHz APB clock and a power-system cycle tick from the
// frequency tracker in the same clock domain.
package ocic_pkg;

    localparam int NUM_OUT   = 23;
    localparam int NUM_IN    = 14;
    localparam int NUM_SHORT = 8;

    // Clock rate, for reference of time figures
    localparam int CLK_HZ = 10000000;

    // Byte offsets of the APB registers
    localparam logic [7:0] ADDR_LATCH    = 8'h00;
    localparam logic [7:0] ADDR_PULSE    = 8'h04;
    localparam logic [7:0] ADDR_POLARITY = 8'h08;
    localparam logic [7:0] ADDR_IN_STATE = 8'h0C;
    localparam logic [7:0] ADDR_OUT_ST   = 8'h10;
    localparam logic [7:0] ADDR_INT_STAT = 8'h14;
    localparam logic [7:0] ADDR_INT_MASK = 8'h18;
    localparam logic [7:0] ADDR_VT_PHASE = 8'h20;
    localparam logic [7:0] ADDR_VT_NEUT  = 8'h24;
    localparam logic [7:0] ADDR_VT_AUX   = 8'h28;
    localparam logic [7:0] ADDR_CT_PHASE = 8'h2C;
    localparam logic [7:0] ADDR_CT_NEUT  = 8'h30;
    localparam logic [7:0] ADDR_SEAL_BASE = 8'h80;

    // Ratio limits; VT ratios held in tenths
    localparam logic [15:0] VT_RATIO_MIN = 16'h000A;
    localparam logic [15:0] VT_RATIO_MAX = 16'hFFDC;
    localparam logic [15:0] CT_RATIO_MIN = 16'h0001;
    localparam logic [15:0] CT_RATIO_MAX = 16'hFFDC;

    // Seal-in limits in power-system cycles
    localparam logic [15:0] SEAL_SHORT_MIN = 16'h0002;
    localparam logic [15:0] SEAL_SHORT_MAX = 16'h1FE0;
    localparam logic [15:0] SEAL_LONG_MIN  = 16'h0000;
    localparam logic [15:0] SEAL_LONG_MAX  = 16'hFFFF;

    // Reset values
    localparam logic [15:0] RST_SEAL_SHORT = 16'h001E;
    localparam logic [15:0] RST_SEAL_LONG  = 16'h0000;
    localparam logic [15:0] RST_VT_PHASE   = 16'h04B0;
    localparam logic [15:0] RST_VT_NEUT    = 16'h01F4;
    localparam logic [15:0] RST_VT_AUX     = 16'h000A;
    localparam logic [15:0] RST_CT_RATIO   = 16'h0640;

    typedef enum logic [1:0] {
        OCIC_IDLE = 2'b00,
        OCIC_SEAL = 2'b01,
        OCIC_HOLD = 2'b11,
        OCIC_DONE = 2'b10
    } ocic_state_t;

    typedef struct packed {
        logic        latched;
        logic        pulsed;
        logic [15:0] seal;
    } ocic_chan_cfg_t;

    function automatic logic [15:0] ocic_clamp(input logic [15:0] v,
                                               input logic [15:0] lo,
                                               input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

endpackage

// ==== ocic_channel.sv ====
// One output contact channel: mode handling and seal-in timer.
// Assumes trip request and cycle tick are synchronous to pclk.
`timescale 1ns/1ps
module ocic_channel (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire ocic_pkg::ocic_chan_cfg_t cfg,
    input  wire logic                    trip_req,
    input  wire logic                    cycle_tick,
    input  wire logic                    target_clear,
    output logic                         contact,
    output logic                         pickup
);

    ocic_pkg::ocic_state_t state_ff;
    ocic_pkg::ocic_state_t nxt_state;
    logic [15:0]           cnt_ff;
    logic [15:0]           nxt_cnt;
    logic                  contact_ff;
    logic                  nxt_contact;
    logic                  pickup_ff;
    logic                  nxt_pickup;

    wire expired = (cnt_ff == 16'h0000);
    wire pulse_en = cfg.pulsed & ~cfg.latched;

    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_contact = contact_ff;
        nxt_pickup  = 1'b0;
        case (state_ff)
            ocic_pkg::OCIC_IDLE: begin
                // R14 timer starts at pickup
                if (trip_req) begin
                    nxt_state   = ocic_pkg::OCIC_SEAL;
                    nxt_cnt     = cfg.seal;
                    nxt_contact = 1'b1;
                    nxt_pickup  = 1'b1;
                end
            end
            ocic_pkg::OCIC_SEAL: begin
                // R4 held for seal-in time
                if (expired) begin
                    if (cfg.latched) begin
                        nxt_state = ocic_pkg::OCIC_HOLD;
                    // R12 pulsed drops at expiry
                    end else if (pulse_en) begin
                        nxt_state   = ocic_pkg::OCIC_DONE;
                        nxt_contact = 1'b0;
                    // R9 normal resets after seal
                    end else if (trip_req) begin
                        nxt_state = ocic_pkg::OCIC_HOLD;
                    end else begin
                        nxt_state   = ocic_pkg::OCIC_IDLE;
                        nxt_contact = 1'b0;
                    end
                end else if (cycle_tick) begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            ocic_pkg::OCIC_HOLD: begin
                // R1 R2 latched until clear
                if (cfg.latched) begin
                    if (target_clear) begin
                        nxt_state   = ocic_pkg::OCIC_IDLE;
                        nxt_contact = 1'b0;
                    end
                // R8 normal follows condition
                end else if (!trip_req) begin
                    nxt_state   = ocic_pkg::OCIC_IDLE;
                    nxt_contact = 1'b0;
                end
            end
            ocic_pkg::OCIC_DONE: begin
                if (!trip_req) begin
                    nxt_state = ocic_pkg::OCIC_IDLE;
                end
            end
            default: begin
                nxt_state   = ocic_pkg::OCIC_IDLE;
                nxt_contact = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= ocic_pkg::OCIC_IDLE;
            cnt_ff     <= 16'h0000;
            contact_ff <= 1'b0;
            pickup_ff  <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            contact_ff <= nxt_contact;
            pickup_ff  <= nxt_pickup;
        end
    end

    assign contact = contact_ff;
    assign pickup  = pickup_ff;

endmodule // ocic_channel

// ==== ocic_props.sv ====
// Port checker of the output contact conditioner, bound to its top.
// Assumes the APB master holds each request until pready is seen.
`timescale 1ns/1ps
module ocic_props (
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire logic [ocic_pkg::NUM_OUT-1:0] trip_req,
    input wire logic [ocic_pkg::NUM_OUT-1:0] output_contact,
    input wire logic                         irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait_answer;
        !pready ##1 pready;
    endsequence

    a_ready_wait: assert property (s_setup |=> s_wait_answer)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_zero: assert property (pready && pslverr && !pwrite
                                 |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    a_reset_quiet: assert property (disable iff (1'h0)
        !presetn |-> output_contact == '0 && !irq && !pready)
        else $error("outputs active during reset");

    for (genvar g = 0; g < ocic_pkg::NUM_SHORT; g++) begin : g_ch
        a_contact_cause: assert property (
            $rose(output_contact[g]) |-> $past(trip_req[g]))
            else $error("contact picked up without request");
        a_contact_min: assert property (
            $rose(output_contact[g]) |=> output_contact[g] [*2])
            else $error("contact dropped before seal-in");
    end
endmodule // ocic_props

bind ocic_top ocic_props ocic_props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trip_req(trip_req), .output_contact(output_contact), .irq(irq));

// ==== ocic_field.sv ====
// Field contacts wired to the status inputs; 1 means contact closed.
// Assumes the bench sets wanted states; pins follow after LAG cycles.
`timescale 1ns/1ps
module ocic_field #(
    parameter int LAG = 0
) (
    input  wire logic                        pclk,
    input  wire logic [ocic_pkg::NUM_IN-1:0] closed_req,
    output logic      [ocic_pkg::NUM_IN-1:0] status_pin
);
    logic [ocic_pkg::NUM_IN-1:0] stage_ff [0:7];

    // Slow contacts: mechanical travel delay
    always_ff @(posedge pclk) begin
        stage_ff[0] <= closed_req;
        for (int i = 1; i < 8; i++) begin
            stage_ff[i] <= stage_ff[i-1];
        end
    end
    assign status_pin = (LAG == 0) ? closed_req
                                   : stage_ff[(LAG > 0) ? LAG - 1 : 0];
endmodule // ocic_field

// ==== tb.sv ====
// Self-checking bench of the output contact conditioner.
// Assumes one 10 MHz clock; ticks and trip requests come from here.
`timescale 1ns/1ps
module tb;
    logic                         pclk, presetn, psel, penable, pwrite;
    logic                         pready, pslverr, irq, rerr;
    logic                         cycle_tick, target_reset_pin;
    logic [7:0]                   paddr;
    logic [31:0]                  pwdata, prdata, rdat;
    logic [ocic_pkg::NUM_OUT-1:0] trip_req, output_contact;
    logic [ocic_pkg::NUM_IN-1:0]  status_pin, status_active, closed_req;
    int                           mismatches, samples_checked;

    ocic_top ocic_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trip_req(trip_req), .cycle_tick(cycle_tick),
        .target_reset_pin(target_reset_pin), .status_pin(status_pin),
        .output_contact(output_contact), .status_active(status_active),
        .irq(irq));
    ocic_field #(.LAG(3)) ocic_field_i (.pclk(pclk),
        .closed_req(closed_req), .status_pin(status_pin));

    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches=%0d samples_checked=%0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (int n = 0; n < 20 && pready !== 1'h1; n++) @(posedge pclk);
        if (pready !== 1'h1) begin
            mismatches++;
            print_verdict();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rdat, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge pclk);
            cycle_tick <= 1'h1;
            @(posedge pclk);
            cycle_tick <= 1'h0;
        end
    endtask

    function automatic logic [7:0] seal_addr(input int g);
        return ocic_pkg::ADDR_SEAL_BASE + 8'(g * 4);
    endfunction

    task automatic t_reset_values();
        rd(ocic_pkg::ADDR_VT_PHASE, 32'h04B0);
        rd(ocic_pkg::ADDR_VT_NEUT, 32'h01F4);
        rd(ocic_pkg::ADDR_VT_AUX, 32'h000A);
        rd(ocic_pkg::ADDR_CT_PHASE, 32'h0640);
        rd(ocic_pkg::ADDR_CT_NEUT, 32'h0640);
        rd(seal_addr(0), 32'h001E);
        rd(seal_addr(22), 32'h0000);
        rd(8'h40, 32'h0);
        chk(32'(rerr), 32'h1);
    endtask

    task automatic t_ranges();
        logic [7:0]  ad [8];
        logic [31:0] wv [8];
        logic [31:0] ev [8];
        ad = '{ocic_pkg::ADDR_VT_PHASE, ocic_pkg::ADDR_VT_AUX,
               ocic_pkg::ADDR_CT_NEUT, ocic_pkg::ADDR_CT_PHASE,
               seal_addr(7), seal_addr(7), seal_addr(9),
               ocic_pkg::ADDR_VT_NEUT};
        wv = '{32'h0, 32'hFFFF, 32'h0, 32'hFFFF, 32'h0, 32'hFFFF, 32'hFFFF,
               32'h1234};
        ev = '{32'hA, 32'hFFDC, 32'h1, 32'hFFDC, 32'h2, 32'h1FE0, 32'hFFFF,
               32'h1234};
        for (int i = 0; i < 8; i++) begin
            wr(ad[i], wv[i]);
            rd(ad[i], ev[i]);
        end
    endtask

    task automatic t_normal();
        wr(ocic_pkg::ADDR_INT_MASK, 32'h1);
        wr(seal_addr(0), 32'h2);
        wr(seal_addr(8), 32'h5);
        @(posedge pclk);
        trip_req[0] <= 1'h1;
        trip_req[8] <= 1'h1;
        repeat (2) @(posedge pclk);
        trip_req[8] <= 1'h0;
        chk(32'(output_contact), 32'h0101);
        tick(1);
        trip_req[8] <= 1'h1;
        @(posedge pclk);
        trip_req[8] <= 1'h0;
        tick(1);
        repeat (3) @(posedge pclk);
        chk(32'(output_contact), 32'h0101);
        tick(3);
        repeat (3) @(posedge pclk);
        chk(32'(output_contact), 32'h0001);
        trip_req[0] <= 1'h0;
        repeat (3) @(posedge pclk);
        chk(32'(output_contact), 32'h0);
    endtask

    task automatic t_irq();
        rd(ocic_pkg::ADDR_INT_STAT, 32'h0101);
        chk(32'(irq), 32'h1);
        wr(ocic_pkg::ADDR_INT_STAT, 32'h0001);
        rd(ocic_pkg::ADDR_INT_STAT, 32'h0100);
        chk(32'(irq), 32'h0);
        wr(ocic_pkg::ADDR_INT_MASK, 32'h0100);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h1);
        wr(ocic_pkg::ADDR_INT_STAT, 32'h0100);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0);
    endtask

    task automatic t_modes();
        wr(ocic_pkg::ADDR_LATCH, 32'h2);
        wr(ocic_pkg::ADDR_PULSE, 32'h6);
        rd(ocic_pkg::ADDR_PULSE, 32'h4);
        wr(seal_addr(1), 32'h2);
        wr(seal_addr(2), 32'h2);
        @(posedge pclk);
        trip_req[1] <= 1'h1;
        trip_req[2] <= 1'h1;
        @(posedge pclk);
        trip_req[1] <= 1'h0;
        @(posedge pclk);
        chk(32'(output_contact), 32'h6);
        tick(3);
        repeat (3) @(posedge pclk);
        chk(32'(output_contact), 32'h2);
        rd(ocic_pkg::ADDR_OUT_ST, 32'h2);
        trip_req[2] <= 1'h0;
        target_reset_pin <= 1'h1;
        repeat (6) @(posedge pclk);
        target_reset_pin <= 1'h0;
        chk(32'(output_contact), 32'h0);
        wr(ocic_pkg::ADDR_LATCH, 32'h4);
        rd(ocic_pkg::ADDR_PULSE, 32'h0);
        wr(ocic_pkg::ADDR_LATCH, 32'h0);
    endtask

    task automatic t_polarity();
        closed_req <= 14'h0F0F;
        wr(ocic_pkg::ADDR_POLARITY, 32'h3333);
        repeat (8) @(posedge pclk);
        chk(32'(status_active), 32'h3C3C);
        closed_req <= 14'h3FFF;
        repeat (8) @(posedge pclk);
        rd(ocic_pkg::ADDR_IN_STATE, 32'h0CCC);
    endtask

    initial begin
        {psel, penable, pwrite, cycle_tick, target_reset_pin} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        trip_req = '0;
        closed_req = '0;
        mismatches = 0;
        samples_checked = 0;
        // Scheduled so the async reset edge is seen at time zero
        presetn <= 1'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        t_reset_values();
        t_ranges();
        t_normal();
        t_irq();
        t_modes();
        t_polarity();
        print_verdict();
    end
endmodule // tb
